/* File: design/self_program_flash_ctrl.sv */
// Purpose: self-programming flash controller with apb register access
// Assumes: cpu store/load events arrive as pins synchronous to pclk
// Notes: flash macro itself lives outside; this block sequences and times it
// Behaviour
// - ready interrupt asserted steadily while enabled and operation-enable clear
// - erase or write in progress blocks reads of the read-while-write section, unless a system reset clears the busy flag mid-operation
// - section busy flag stays set while the section is busy or blocked
// - lock-set programs each lock bit whose data bit 5..0 is zero
// - pointer ignored during lock-set; host may load 0x0001
// - whole flash stays readable while lock bits are programmed
// - eeprom write in progress refuses every flash programming command
// - eeprom write in progress refuses fuse and lock readout
// - pointer 0x0001, readout bits set, load within three cycles returns lock bits
// - lock-select and enable self-clear on readout or on the four-cycle store-window timeout
// - pointer 0x0000 readout returns fuse low byte
// - pointer 0x0003 readout returns fuse high byte
// - pointer 0x0002 readout returns extended fuse byte
// - readout shows programmed bits as zero, unprogrammed as one
// - write running at reset still completes
// - erase, write and lock write last between 3.7 ms and 4.5 ms
// - operation-enable stays set while erase or write busy, clears after
// - section cannot be re-enabled while erase or write runs
`timescale 1ns/1ps
`default_nettype none
module self_program_flash_ctrl
  import spm_pkg::*;
#(
  parameter int PROG_TIME = PROG_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic porn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic store_strobe,
  input wire logic load_strobe,
  input wire logic eeprom_write_busy_flag,
  output logic irq,
  output logic section_read_block,
  output logic flash_erase_pulse,
  output logic flash_write_pulse,
  output logic [5:0] lock_bits
);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  initial begin
    if (PROG_TIME < 1 || PROG_TIME > PROG_MAX_CYCLES) $error("programming time out of range");
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  apb_req_t req;
  assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};
  wire access = req.psel && req.penable;
  wire wr = access && req.pwrite;
  // read data registered in setup so it stands while pready is high
  wire rd = req.psel && !req.penable && !req.pwrite;
  wire hit_csr = (req.paddr == CSR_ADDR);
  wire hit_data = (req.paddr == DATA_ADDR);
  wire hit_ptr = (req.paddr == PTR_ADDR);
  wire hit_cmd = (req.paddr == CMD_ADDR);
  wire hit_fuse = (req.paddr == FUSE_ADDR);
  wire hit_res = (req.paddr == RESULT_ADDR);
  wire hit_ee = (req.paddr == EE_ADDR);
  wire mapped = hit_csr | hit_data | hit_ptr | hit_cmd | hit_fuse | hit_res | hit_ee;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_t state_reg;
  state_t state_next;
  op_t op_reg;
  logic ie_reg;
  logic busy_reg;
  logic [4:1] cmd_reg;
  logic [7:0] data_reg;
  logic [15:0] ptr_reg;
  logic [7:0] result_reg;
  logic [23:0] fuse_reg;
  logic [5:0] lock_reg;
  logic [5:0] lock_pend_reg;
  logic win_open;
  logic win_expired;
  logic lwin_open;
  logic lwin_expired;
  logic prog_busy;
  logic prog_done;

  wire csr_write = wr && hit_csr && (state_reg != ST_PROG) && !prog_busy;
  // eeprom activity blocks any control write that would start a command
  wire csr_take = csr_write && !eeprom_write_busy_flag && pwdata[EN_POS];
  wire is_lock = csr_take && pwdata[LOCK_POS];
  wire armed = (state_reg == ST_ARMED);
  wire store_go = armed && store_strobe && win_open && !eeprom_write_busy_flag;
  wire load_go = armed && load_strobe && lwin_open && op_reg == OP_LOCK
    && !eeprom_write_busy_flag;
  wire rre_cmd = cmd_reg[RRE_POS];
  // re-enable only when nothing programs; enable bit in state covers it
  wire reenable = store_go && rre_cmd && !prog_busy;
  wire prog_start = store_go && !rre_cmd && (op_reg != OP_NONE);
  wire page_load = store_go && (op_reg == OP_NONE) && !rre_cmd;
  wire timeout = armed && win_expired;
  // a system reset mid-write leaves the timer running, so enable follows it too
  wire en_bit = (state_reg != ST_IDLE) || prog_busy;

  spm_window_timer #(.WIDTH(3)) u_store_win (
    .pclk(pclk),
    .presetn(presetn),
    .load(csr_take),
    .stop(store_go || load_go),
    .count(3'(STORE_WINDOW)),
    .open(win_open),
    .expired(win_expired)
  );

  spm_window_timer #(.WIDTH(3)) u_load_win (
    .pclk(pclk),
    .presetn(presetn),
    .load(is_lock),
    .stop(store_go || load_go),
    .count(3'(LOAD_WINDOW)),
    .open(lwin_open),
    .expired(lwin_expired)
  );

  // programming timer sits on power-on reset so a system reset lets it finish
  spm_prog_timer #(.CYCLES(PROG_TIME)) u_prog (
    .pclk(pclk),
    .porn(porn),
    .start(prog_start),
    .busy(prog_busy),
    .done(prog_done)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (csr_take) state_next = ST_ARMED;
      end
      ST_ARMED: begin
        if (prog_start) state_next = ST_PROG;
        else if (store_go || load_go || timeout) state_next = ST_IDLE;
      end
      ST_PROG: begin
        if (prog_done) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_NONE;
      cmd_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (csr_take) begin
        cmd_reg <= pwdata[4:1];
        op_reg <= pwdata[LOCK_POS] ? OP_LOCK : pwdata[WRT_POS] ? OP_WRITE
          : pwdata[ERS_POS] ? OP_ERASE : OP_NONE;
      end else if (state_next == ST_IDLE) begin
        cmd_reg <= '0;
        op_reg <= OP_NONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // section busy and lock storage
  // ----------------------------------------------------------------
  wire sect_prog = prog_start && (op_reg != OP_LOCK);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      ie_reg <= 1'b0;
    end else begin
      if (sect_prog) busy_reg <= 1'b1;
      else if ((reenable || page_load) && !prog_busy) busy_reg <= 1'b0;
      if (csr_write) ie_reg <= pwdata[IE_POS];
    end
  end

  // lock bits held on power-on reset: non-volatile stand-in
  always_ff @(posedge pclk or negedge porn) begin
    if (!porn) begin
      lock_reg <= LOCK_RESET;
      lock_pend_reg <= LOCK_RESET;
    end else begin
      if (prog_start && op_reg == OP_LOCK) lock_pend_reg <= lock_reg & data_reg[5:0];
      if (prog_done) lock_reg <= lock_pend_reg;
    end
  end

  // ----------------------------------------------------------------
  // readout
  // ----------------------------------------------------------------
  // stored values use 0 = programmed, so readout is a straight copy
  wire [7:0] readout = (ptr_reg == PTR_LOCK) ? {2'b11, lock_reg}
    : (ptr_reg == PTR_FUSE_LOW) ? fuse_reg[7:0]
    : (ptr_reg == PTR_FUSE_HIGH) ? fuse_reg[15:8]
    : (ptr_reg == PTR_FUSE_EXT) ? fuse_reg[23:16]
    : 8'hFF;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= 8'hFF;
      ptr_reg <= 16'h0000;
      result_reg <= 8'h00;
      fuse_reg <= {FUSE_EXT_RESET, FUSE_HIGH_RESET, FUSE_LOW_RESET};
    end else begin
      if (wr && hit_data) data_reg <= pwdata[7:0];
      if (wr && hit_ptr) ptr_reg <= pwdata[15:0];
      if (wr && hit_fuse) fuse_reg <= pwdata[23:0];
      if (load_go) result_reg <= readout;
    end
  end

  // ----------------------------------------------------------------
  // apb read path and outputs
  // ----------------------------------------------------------------
  wire [7:0] csr_view = {ie_reg, busy_reg, 1'b0, cmd_reg, en_bit};
  wire [31:0] rdata_next = hit_csr ? {24'h0, csr_view}
    : hit_data ? {24'h0, data_reg}
    : hit_ptr ? {16'h0, ptr_reg}
    : hit_cmd ? {30'h0, prog_busy, win_open}
    : hit_fuse ? {8'h0, fuse_reg}
    : hit_res ? {24'h0, result_reg}
    : hit_ee ? {31'h0, eeprom_write_busy_flag}
    : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      section_read_block <= 1'b0;
      flash_erase_pulse <= 1'b0;
      flash_write_pulse <= 1'b0;
      lock_bits <= LOCK_RESET;
    end else begin
      pready <= req.psel && !req.penable;
      pslverr <= req.psel && !req.penable && !mapped;
      if (rd) prdata <= rdata_next;
      irq <= ie_reg && !en_bit;
      // lock programming leaves the whole array readable
      section_read_block <= busy_reg || sect_prog;
      flash_erase_pulse <= prog_start && op_reg == OP_ERASE;
      flash_write_pulse <= prog_start && op_reg == OP_WRITE;
      lock_bits <= lock_reg;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_lock_load;
    armed && op_reg == OP_LOCK && ptr_reg == PTR_LOCK && load_go;
  endsequence

  a_irq_level: assert property (ie_reg && !en_bit |=> irq)
    else $error("irq not following enable");
  a_irq_quiet: assert property (en_bit |=> !irq)
    else $error("irq raised while operation enabled");
  a_lock_open: assert property (prog_start && op_reg == OP_LOCK && !busy_reg
    |=> !section_read_block)
    else $error("lock programming blocked the section");
  a_ee_no_load: assert property (eeprom_write_busy_flag && load_strobe |=> $stable(result_reg))
    else $error("readout taken during eeprom write");
  a_busy_holds: assert property (prog_busy && !prog_start && busy_reg |=> busy_reg)
    else $error("busy dropped while programming");
  a_block_read: assert property (busy_reg |=> section_read_block)
    else $error("section not blocked");
  a_ee_refuse: assert property (eeprom_write_busy_flag && state_reg == ST_IDLE
    |=> state_reg == ST_IDLE)
    else $error("command taken during eeprom write");
  a_lock_read: assert property (s_lock_load |=> result_reg == {2'b11, $past(lock_reg)})
    else $error("lock readout wrong");
  a_window_close: assert property (is_lock ##1 (!store_strobe && !load_strobe)[*5]
    |=> !en_bit)
    else $error("window did not close");
  a_en_while_prog: assert property (prog_start |=> prog_busy && state_reg == ST_PROG)
    else $error("enable clear during programming");
  a_no_change: assert property (timeout |=> $stable(lock_pend_reg) && !prog_busy)
    else $error("timeout changed state");
endmodule : self_program_flash_ctrl
`default_nettype wire

/* File: design/spm_pkg.sv */
// Purpose: shared constants and types for the self-programming flash controller
// Assumes: 250 MHz pclk, 32-bit APB
// Notes: control word layout follows the 8-bit control/status register
package spm_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CSR_ADDR = 8'h00;
  localparam logic [7:0] DATA_ADDR = 8'h04;
  localparam logic [7:0] PTR_ADDR = 8'h08;
  localparam logic [7:0] CMD_ADDR = 8'h0C;
  localparam logic [7:0] FUSE_ADDR = 8'h10;
  localparam logic [7:0] RESULT_ADDR = 8'h14;
  localparam logic [7:0] EE_ADDR = 8'h18;
  // ----------------------------------------------------------------
  // control/status fields
  // ----------------------------------------------------------------
  localparam int IE_POS = 7;
  localparam int BUSY_POS = 6;
  localparam int RRE_POS = 4;
  localparam int LOCK_POS = 3;
  localparam int WRT_POS = 2;
  localparam int ERS_POS = 1;
  localparam int EN_POS = 0;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [5:0] LOCK_RESET = 6'h3F;
  // plain all-ones defaults: every fuse reads unprogrammed until software loads the stand-in
  localparam logic [7:0] FUSE_LOW_RESET = 8'hFF;
  localparam logic [7:0] FUSE_HIGH_RESET = 8'hFF;
  localparam logic [7:0] FUSE_EXT_RESET = 8'hFF;
  // lpm pointer values selecting readout bytes
  localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
  localparam logic [15:0] PTR_LOCK = 16'h0001;
  localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int STORE_WINDOW = 4;
  localparam int LOAD_WINDOW = 3;
  localparam int PROG_MIN_US = 3700;
  localparam int PROG_MAX_US = 4500;
  // least time rounds up; 3.7 ms sits inside 3.7..4.5 ms
  localparam int PROG_CYCLES = PROG_MIN_US * CLK_MHZ;
  localparam int PROG_MAX_CYCLES = PROG_MAX_US * CLK_MHZ;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_PROG = 2'b11
  } state_t;
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_ERASE = 2'b01,
    OP_WRITE = 2'b10,
    OP_LOCK = 2'b11
  } op_t;
  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage : spm_pkg

/* File: design/spm_window_timer.sv */
// Purpose: down-counter for the store and load windows after a control write
// Assumes: load pulse restarts the count
// Notes: expired is a one-cycle pulse when the window runs out
`timescale 1ns/1ps
`default_nettype none
module spm_window_timer
  import spm_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic stop,
  input wire logic [WIDTH-1:0] count,
  output logic open,
  output logic expired
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  wire last_tick = (cnt_reg == WIDTH'(1));

  assign cnt_next = load ? count : (stop ? '0 : ((cnt_reg != '0) ? cnt_reg - WIDTH'(1) : '0));
  assign open = (cnt_reg != '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      expired <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      expired <= last_tick && !load && !stop;
    end
  end
endmodule : spm_window_timer
`default_nettype wire

/* File: design/spm_prog_timer.sv */
// Purpose: rc-timed programming duration counter
// Assumes: started by a one-cycle pulse
// Notes: keeps running through a reset; only power-up clears it
`timescale 1ns/1ps
`default_nettype none
module spm_prog_timer
  import spm_pkg::*;
#(
  parameter int CYCLES = PROG_CYCLES
) (
  input wire logic pclk,
  input wire logic porn,
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_reg;
  wire finishing = busy && (cnt_reg == W'(1));

  initial begin
    if (CYCLES < 1) $error("programming time must be at least one cycle");
  end

  always_ff @(posedge pclk or negedge porn) begin
    if (!porn) begin
      cnt_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= finishing;
      if (start && !busy) begin
        cnt_reg <= W'(CYCLES);
        busy <= 1'b1;
      end else if (busy) begin
        cnt_reg <= cnt_reg - W'(1);
        busy <= !finishing;
      end
    end
  end
endmodule : spm_prog_timer
`default_nettype wire

/* File: tb/cpu_core_model.sv */
// Purpose: cpu core model issuing store and load instructions
// Assumes: fire is a one-cycle request from the bench
// Notes: gap delays the instruction; a gap of 3 lets the store window lapse
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire logic is_load,
  input wire logic [1:0] gap,
  output logic store_strobe,
  output logic load_strobe
);
  logic [1:0] cnt_reg;
  logic act_reg, kind_reg, due;
  assign due = act_reg && cnt_reg == 2'h0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 2'h0;
      act_reg <= 1'b0;
      kind_reg <= 1'b0;
      store_strobe <= 1'b0;
      load_strobe <= 1'b0;
    end else begin
      store_strobe <= (fire && !is_load && gap == 2'h0) || (due && !kind_reg);
      load_strobe <= (fire && is_load && gap == 2'h0) || (due && kind_reg);
      if (fire) begin
        act_reg <= gap != 2'h0;
        cnt_reg <= gap - 2'h1;
        kind_reg <= is_load;
      end else if (act_reg) begin
        cnt_reg <= cnt_reg - 2'h1;
        act_reg <= cnt_reg != 2'h0;
      end
    end
  end
endmodule : cpu_core_model
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for the flash self-programming controller
// Assumes: programming time shortened to 20 cycles
// Notes: reads queue their expectation; a watcher compares at completion
`timescale 1ns/1ps
`default_nettype none
module tb;
  import spm_pkg::*;
  localparam int PT = 20;
  logic pclk = 0, presetn = 0, porn = 0, psel = 0, penable = 0, pwrite = 0;
  logic ee = 0, fire = 0, is_load = 0;
  logic [1:0] gap = 2'h0;
  logic [7:0] paddr = 8'h00, x;
  logic [31:0] pwdata = 32'h0, prdata, q, fv, ld;
  logic pready, pslverr, store_strobe, load_strobe, irq, section_read_block;
  logic flash_erase_pulse, flash_write_pulse;
  logic [5:0] lock_bits, lk;
  logic [64:0] exp_q[$];
  logic [64:0] e;
  int mismatches = 0, checked = 0, seed = 98436, ers_n = 0, wrt_n = 0, cyc = 0, t_ers = 0;
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (flash_erase_pulse === 1'b1) begin
      ers_n <= ers_n + 1;
      t_ers <= cyc;
    end
    if (flash_write_pulse === 1'b1) wrt_n <= wrt_n + 1;
  end
  self_program_flash_ctrl #(.PROG_TIME(PT)) i_dut (.pclk(pclk), .presetn(presetn), .porn(porn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .store_strobe(store_strobe),
    .load_strobe(load_strobe), .eeprom_write_busy_flag(ee), .irq(irq),
    .section_read_block(section_read_block), .flash_erase_pulse(flash_erase_pulse),
    .flash_write_pulse(flash_write_pulse), .lock_bits(lock_bits));
  // core model takes no interrupts, so no vector fetch can hit the blocked section
  cpu_core_model i_cpu (.pclk(pclk), .presetn(presetn), .fire(fire), .is_load(is_load),
    .gap(gap), .store_strobe(store_strobe), .load_strobe(load_strobe));
  // --------------------------------------------------------------
  // bus and check tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // error expected only above the last mapped word
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    exp_q.push_back({a > EE_ADDR, m, v & m});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic cpu(input logic l, input logic [1:0] g);
    fire <= 1'b1;
    is_load <= l;
    gap <= g;
    @(posedge pclk);
    fire <= 1'b0;
  endtask : cpu
  task automatic idle();
    int n;
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 60) begin
      rd(CSR_ADDR, 32'h0, 32'h0);
      n++;
    end
    chk({31'h0, q[0]}, 32'h0);
  endtask : idle
  task automatic test_done();
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  always @(negedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[64]});
      chk(prdata & e[63:32], e[31:0]);
    end
  end
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    test_done();
  end
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    porn <= 1'b1;
    ld = $random(seed);
    lk = ld[5:0];
    apb(1'b1, DATA_ADDR, {24'h0, 2'b11, ld[5:0]});
    apb(1'b1, PTR_ADDR, ld);
    apb(1'b1, CSR_ADDR, 32'h09);
    cpu(1'b0, ld[7:6] & 2'h1);
    repeat (3) @(posedge pclk);
    chk({31'h0, section_read_block}, 32'h0);
    rd(CSR_ADDR, 32'h1, 32'h1);
    idle();
    chk({26'h0, lock_bits}, {26'h0, lk});
    apb(1'b1, DATA_ADDR, 32'hC0);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, CSR_ADDR, 32'h09);
      if (k == 0) cpu(1'b0, 2'h3);
      repeat (6) @(posedge pclk);
      rd(CSR_ADDR, 32'h0, 32'h0F);
      chk({26'h0, lock_bits}, {26'h0, lk});
    end
    fv = $random(seed);
    apb(1'b1, FUSE_ADDR, fv);
    for (int p = 0; p < 4; p++) begin
      x = p == 0 ? fv[7:0] : p == 1 ? {2'b11, lk} : p == 2 ? fv[23:16] : fv[15:8];
      apb(1'b1, PTR_ADDR, 32'(p));
      apb(1'b1, CSR_ADDR, 32'h09);
      cpu(1'b1, 2'h0);
      repeat (3) @(posedge pclk);
      rd(RESULT_ADDR, {24'h0, x}, p == 1 ? 32'h3F : 32'hFF);
      rd(CSR_ADDR, 32'h0, 32'h09);
    end
    // eeprom busy: both the readout and the erase must be refused
    ee <= 1'b1;
    apb(1'b1, PTR_ADDR, 32'h0);
    apb(1'b1, CSR_ADDR, 32'h09);
    cpu(1'b1, 2'h0);
    apb(1'b1, CSR_ADDR, 32'h03);
    cpu(1'b0, 2'h0);
    repeat (4) @(posedge pclk);
    rd(RESULT_ADDR, {24'h0, fv[15:8]}, 32'hFF);
    chk(ers_n, 0);
    ee <= 1'b0;
    rd(EE_ADDR, 32'h0, 32'h1);
    apb(1'b1, CSR_ADDR, 32'h83);
    cpu(1'b0, 2'h1);
    repeat (3) @(posedge pclk);
    chk({30'h0, irq, section_read_block}, 32'h1);
    rd(CSR_ADDR, 32'hC1, 32'hE1);
    apb(1'b1, CSR_ADDR, 32'h91);
    cpu(1'b0, 2'h0);
    idle();
    chk({31'h0, cyc - t_ers >= PT && cyc - t_ers <= PT + 8}, 32'h1);
    chk({30'h0, irq, section_read_block}, 32'h3);
    apb(1'b1, CSR_ADDR, 32'h11);
    cpu(1'b0, 2'h0);
    repeat (3) @(posedge pclk);
    rd(CSR_ADDR, 32'h0, 32'h41);
    chk({31'h0, section_read_block}, 32'h0);
    apb(1'b1, CSR_ADDR, 32'h05);
    cpu(1'b0, 2'h0);
    repeat (4) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(CMD_ADDR, 32'h2, 32'h2);
    repeat (PT) @(posedge pclk);
    rd(CMD_ADDR, 32'h0, 32'h2);
    chk(wrt_n, 1);
    rd(8'h1C, 32'h0, 32'h0);
    test_done();
  end
endmodule : tb
`default_nettype wire
